// ===== bac_pkg.sv
package bac_pkg;

    // serial frame
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LAST = 5'h0F;
    localparam logic [4:0] FRAME_DONE = 5'h10;
    localparam int WR_POS = 15;
    localparam int SEL_HI = 14;
    localparam int SEL_LO = 13;
    localparam int CTRL_HI = 12;
    localparam int CTRL_LO = 1;
    localparam int RANGE_HI = 12;
    localparam int RANGE_LO = 5;
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_RANGE1 = 2'h1;
    localparam logic [1:0] SEL_RANGE2 = 2'h2;
    localparam logic [1:0] SEL_SEQ = 2'h3;

    // conversion result
    localparam int CODE_BITS = 13;
    localparam int CODE_COUNT = 8192;
    localparam int CH_BITS = 3;

    // throughput limit
    localparam int CLK_KHZ = 25000;
    localparam int MAX_KSPS = 500;
    localparam int CONV_CYC = (CLK_KHZ + MAX_KSPS - 1) / MAX_KSPS;
    localparam logic [7:0] CONV_CYC8 = 8'(CONV_CYC);
    localparam logic [7:0] GAP_MAX = 8'hFF;

    // apb map
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_RANGE = 8'h0C;
    localparam logic [7:0] ADDR_SEQ = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    localparam int ST_OVERRUN = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_BUSY = 2;
    localparam int CFG_LINK_EN = 0;

    // reset values
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [7:0] RANGE_RST = 8'h00;
    localparam logic [7:0] SEQ_RST = 8'h00;
    localparam logic LINK_EN_RST = 1'b1;

    typedef struct packed {
        logic [2:0] channel_addr;
        logic input_config_bit_high;
        logic input_config_bit_low;
        logic [1:0] power_mode;
        logic coding_binary;
        logic ref_internal;
        logic [1:0] seq_mode;
        logic weak_dout;
    } bac_ctrl_type;

    typedef struct packed {
        logic [2:0] channel;
        logic [1:0] range;
        logic [1:0] input_config;
        logic ref_internal;
        logic [1:0] power_mode;
    } bac_fe_type;

    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        logic sclk_d;
        logic cs_d;
        logic active;
        logic [4:0] bitcnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic dout;
        logic dout_oe_n;
        bac_ctrl_type ctrl;
        logic [7:0] range1;
        logic [7:0] range2;
        logic [7:0] seq;
        logic [2:0] cur_ch;
        logic [12:0] result;
        logic [2:0] res_ch;
        logic link_en;
        logic overrun;
        logic abort;
        logic [7:0] gap_cnt;
        logic [31:0] prdata;
        logic pslverr;
        bac_fe_type fe;
        logic sample_strobe;
    } bac_state_type;

    localparam bac_state_type STATE_RST = '{
        sclk_s: 2'h3,
        cs_s: 2'h3,
        sclk_d: 1'b1,
        cs_d: 1'b1,
        dout_oe_n: 1'b1,
        ctrl: CTRL_RST,
        range1: RANGE_RST,
        range2: RANGE_RST,
        seq: SEQ_RST,
        link_en: LINK_EN_RST,
        gap_cnt: GAP_MAX,
        default: '0
    };

endpackage : bac_pkg

// ===== bac_converter_ctrl.sv
`timescale 1ns/10ps
// Operation
// - each channel gets its own range from the two range registers.
// - two input-config bits pick 8 single, 4 diff, 4 or 7 pseudo-diff.
// - host serial clock, sampled on pclk, shifts data and steps the frame bit count.
// - external reference is used after power-up until host selects otherwise.
// - power-down option programmed in control register is applied.
// - results are two's complement unless coding was changed.
// - coding bit set to one gives straight binary results.
// - in sequence mode every channel uses latest written coding bit.
// - span quantised into 8192 codes, thirteen-bit result.
// - up to 500 ksps; faster frames are flagged by the device.
// - frame is 16 clocks; first bits are write flag and two selects.
// - write flag zero updates no register.
// - all control bits reset to zero, eight single-ended inputs.
module bac_converter_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    input wire logic [12:0] sample_code,
    output bac_pkg::bac_fe_type fe,
    output logic sample_strobe
);

    bac_pkg::bac_state_type s;
    bac_pkg::bac_state_type next_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic apb_setup;
    logic apb_write;

    function automatic logic [2:0] next_seq_ch(input logic [2:0] cur, input logic [7:0] mask);
        logic [2:0] res;
        logic [2:0] k;
        logic found;
        res = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            k = cur + 3'(i);
            if (!found && mask[k]) begin
                res = k;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_seq_ch

    // ch0..3 in range1, ch4..7 in range2, lowest channel in top pair
    function automatic logic [1:0] range_of(input logic [2:0] ch, input logic [7:0] r1,
                                            input logic [7:0] r2);
        logic [7:0] r;
        r = ch[2] ? r2 : r1;
        unique case (ch[1:0])
            2'h0: return r[7:6];
            2'h1: return r[5:4];
            2'h2: return r[3:2];
            2'h3: return r[1:0];
        endcase
    endfunction : range_of

    function automatic logic [12:0] code_out(input logic [12:0] smp, input logic binary);
        return binary ? {~smp[12], smp[11:0]} : smp;
    endfunction : code_out

    assign sclk_rise = s.sclk_s[1] & ~s.sclk_d;
    assign sclk_fall = ~s.sclk_s[1] & s.sclk_d;
    assign cs_fall = ~s.cs_s[1] & s.cs_d;
    assign cs_rise = s.cs_s[1] & ~s.cs_d;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;

    always_comb begin
        logic [15:0] w;
        logic [2:0] ch;
        logic [12:0] code;
        logic ovr_set;
        logic abt_set;
        logic ovr_clr;
        logic abt_clr;
        w = '0;
        ch = '0;
        code = '0;
        ovr_set = 1'b0;
        abt_set = 1'b0;
        ovr_clr = 1'b0;
        abt_clr = 1'b0;
        next_s = s;
        next_s.sample_strobe = 1'b0;

        next_s.sclk_s = {s.sclk_s[0], sclk};
        next_s.cs_s = {s.cs_s[0], cs_n};
        next_s.din_s = {s.din_s[0], din};
        next_s.sclk_d = s.sclk_s[1];
        next_s.cs_d = s.cs_s[1];

        if (s.gap_cnt != bac_pkg::GAP_MAX) begin
            next_s.gap_cnt = s.gap_cnt + 8'h01;
        end

        // front-end settings follow the control and range registers
        next_s.fe.input_config = {s.ctrl.input_config_bit_high,
                                  s.ctrl.input_config_bit_low};
        next_s.fe.ref_internal = s.ctrl.ref_internal;
        next_s.fe.power_mode = s.ctrl.power_mode;
        next_s.fe.range = range_of(s.fe.channel, s.range1, s.range2);

        if (cs_fall && s.link_en) begin
            // hold point: pick channel, sample, code with current coding bit
            ch = (s.ctrl.seq_mode != 2'h0) ? next_seq_ch(s.cur_ch, s.seq)
                                          : s.ctrl.channel_addr;
            code = code_out(sample_code, s.ctrl.coding_binary);
            next_s.active = 1'b1;
            next_s.bitcnt = '0;
            next_s.cur_ch = ch;
            next_s.fe.channel = ch;
            next_s.fe.range = range_of(ch, s.range1, s.range2);
            next_s.sample_strobe = 1'b1;
            next_s.result = code;
            next_s.res_ch = ch;
            next_s.tx = {ch, code};
            next_s.dout = ch[2];
            next_s.dout_oe_n = 1'b0;
            ovr_set = (s.gap_cnt < bac_pkg::CONV_CYC8);
            next_s.gap_cnt = '0;
        end else if (s.active) begin
            if (cs_rise) begin
                next_s.active = 1'b0;
                next_s.dout_oe_n = 1'b1;
                abt_set = (s.bitcnt != bac_pkg::FRAME_DONE);
            end else begin
                if (sclk_rise && s.bitcnt != bac_pkg::FRAME_DONE) begin
                    next_s.rx = {s.rx[14:0], s.din_s[1]};
                    next_s.bitcnt = s.bitcnt + 5'h01;
                    if (s.bitcnt == bac_pkg::FRAME_LAST) begin
                        w = {s.rx[14:0], s.din_s[1]};
                        if (w[bac_pkg::WR_POS]) begin
                            unique case (w[bac_pkg::SEL_HI:bac_pkg::SEL_LO])
                                bac_pkg::SEL_CTRL: next_s.ctrl =
                                    bac_pkg::bac_ctrl_type'(w[bac_pkg::CTRL_HI:bac_pkg::CTRL_LO]);
                                bac_pkg::SEL_RANGE1: next_s.range1 =
                                    w[bac_pkg::RANGE_HI:bac_pkg::RANGE_LO];
                                bac_pkg::SEL_RANGE2: next_s.range2 =
                                    w[bac_pkg::RANGE_HI:bac_pkg::RANGE_LO];
                                bac_pkg::SEL_SEQ: next_s.seq =
                                    w[bac_pkg::RANGE_HI:bac_pkg::RANGE_LO];
                            endcase
                        end
                    end
                end
                if (sclk_fall) begin
                    next_s.tx = {s.tx[14:0], 1'b0};
                    next_s.dout = s.tx[14];
                end
            end
        end

        // apb: read data latched in setup, writes act at access edge
        if (apb_setup) begin
            next_s.pslverr = 1'b0;
            unique case (paddr)
                bac_pkg::ADDR_CFG: next_s.prdata = {31'h0, s.link_en};
                bac_pkg::ADDR_STATUS: next_s.prdata = {29'h0, s.active, s.abort, s.overrun};
                bac_pkg::ADDR_CTRL: next_s.prdata = {20'h0, s.ctrl};
                bac_pkg::ADDR_RANGE: next_s.prdata = {16'h0, s.range2, s.range1};
                bac_pkg::ADDR_SEQ: next_s.prdata = {24'h0, s.seq};
                bac_pkg::ADDR_RESULT: next_s.prdata = {16'h0, s.res_ch, s.result};
                default: begin
                    next_s.prdata = '0;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_write && paddr == bac_pkg::ADDR_CFG) begin
            next_s.link_en = pwdata[bac_pkg::CFG_LINK_EN];
        end
        if (apb_write && paddr == bac_pkg::ADDR_STATUS) begin
            ovr_clr = pwdata[bac_pkg::ST_OVERRUN];
            abt_clr = pwdata[bac_pkg::ST_ABORT];
        end
        // set beats clear
        next_s.overrun = (s.overrun & ~ovr_clr) | ovr_set;
        next_s.abort = (s.abort & ~abt_clr) | abt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= bac_pkg::STATE_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = psel & penable;
    assign pslverr = s.pslverr & psel & penable;
    assign dout = s.dout;
    assign dout_oe_n = s.dout_oe_n;
    assign fe = s.fe;
    assign sample_strobe = s.sample_strobe;

endmodule : bac_converter_ctrl

// ===== bac_converter_ctrl_sva.sv
`timescale 1ns/10ps
module bac_converter_ctrl_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire bac_pkg::bac_fe_type fe,
    input wire logic sample_strobe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    apb_ready_a: assert property (pready == (psel && penable))
        else $error("pready does not follow the access phase");
    apb_unmapped_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    reset_state_a: assert property ($rose(presetn) |-> fe == '0 && dout_oe_n)
        else $error("state after reset release not cleared");
    oe_follow_a: assert property ($changed(dout_oe_n) |-> dout_oe_n == cs_n)
        else $error("output enable changed against frame select");
    first_bit_a: assert property ($fell(dout_oe_n) |-> sample_strobe && dout == fe.channel[2])
        else $error("frame start without sample or channel msb");
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    dout_hold_a: assert property (!dout_oe_n && !$past(dout_oe_n) && sclk && $past(sclk)
        && $past(sclk, 2) && $past(sclk, 3) && $past(sclk, 4) |-> $stable(dout))
        else $error("dout changed while serial clock high");
    chan_load_a: assert property ($changed(fe.channel) |-> sample_strobe)
        else $error("channel changed outside frame start");
    cfg_frame_a: assert property ($changed({fe.input_config, fe.ref_internal, fe.power_mode})
        |-> !dout_oe_n || !$past(dout_oe_n))
        else $error("front end setting changed outside a frame");
endmodule : bac_converter_ctrl_sva

bind bac_converter_ctrl bac_converter_ctrl_sva chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe_n(dout_oe_n),
    .fe(fe), .sample_strobe(sample_strobe));

// ===== bac_host.sv
`timescale 1ns/10ps
module bac_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // one frame of 16 clocks, msb first, then a gap that keeps the rate legal
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        // keep link edges off the pclk sampling edge
        #10;
        cs_n = 1'b0;
        din = w[15];
        #320;
        for (int i = 15; i >= 0; i--) begin
            r[i] = dout;
            sclk = 1'b0;
            din = w[i];
            #160;
            sclk = 1'b1;
            #160;
        end
        #160;
        cs_n = 1'b1;
        din = ~din;
        #2000;
    endtask : xfer
endmodule : bac_host

// ===== bac_converter_ctrl_bench.sv
`timescale 1ns/10ps
module bac_converter_ctrl_bench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e;
    logic sclk, cs_n, din, dout, dout_oe_n, sample_strobe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [12:0] sample_code;
    logic [15:0] r;
    bac_pkg::bac_fe_type fe;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #20 pclk = ~pclk;

    bac_converter_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n), .sample_code(sample_code), .fe(fe),
        .sample_strobe(sample_strobe));
    bac_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    task stop_test;
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample_code = 13'h0A5C;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, bac_pkg::ADDR_CFG, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, bac_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        chk({22'h0, fe}, 32'h0);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'h0A5C);
        apb(1'b0, bac_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        host.xfer(16'hC480, r);
        apb(1'b0, bac_pkg::ADDR_RANGE, 32'h0);
        chk(q, 32'h2400);
        host.xfer(16'h9670, r);
        apb(1'b0, bac_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'hB38);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'hBA5C);
        chk({22'h0, fe}, 32'h2D5);
        host.xfer(16'h9650, r);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'hAA5C);
        host.xfer(16'hE880, r);
        host.xfer(16'h8024, r);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'hDA5C);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'h5A5C);
        host.xfer(16'h8004, r);
        chk({16'h0, r}, 32'hDA5C);
        host.xfer(16'h0000, r);
        chk({16'h0, r}, 32'h4A5C);
        apb(1'b0, bac_pkg::ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, bac_pkg::ADDR_CFG, 32'h0);
        apb(1'b0, bac_pkg::ADDR_CFG, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        stop_test();
    end
endmodule : bac_converter_ctrl_bench
